// *** include/cfm_pkg.sv ***
package cfm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CFM_ADDR_IRQ_STATUS = 8'h19;
	localparam logic [7:0] CFM_ADDR_IRQ_MASK = 8'h21;
	localparam logic [7:0] CFM_ADDR_CTRL_ONE = 8'hA8;
	localparam logic [7:0] CFM_ADDR_CTRL_TWO = 8'hA9;
	localparam logic [7:0] CFM_ADDR_DIE_STATUS = 8'hF0;
	localparam logic [7:0] CFM_ADDR_KEY = 8'hF1;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CFM_BIT_HOT = 15;
	localparam int CFM_BIT_COLD = 14;
	localparam int CFM_BIT_DEFECT = 13;
	localparam int CFM_BIT_TIMEOUT = 12;
	localparam int CFM_BIT_END = 11;
	localparam int CFM_BIT_START = 10;
	localparam int CFM_BIT_FAST_RDY = 9;
	localparam int CFM_BIT_LT_HIGH = 2;
	localparam int CFM_BIT_LT_MID = 1;
	localparam int CFM_BIT_LT_LOW = 0;
	localparam int CFM_BIT_NTC_MON = 3;
	localparam int CFM_BIT_HOT_MON = 2;
	localparam int CFM_BIT_COLD_MON = 1;
	localparam int CFM_BIT_TIME_LSB = 8;
	localparam int CFM_BIT_WARN_PAUSE = 0;
	localparam int CFM_BIT_DIE_WARN = 0;
	localparam int CFM_BIT_DIE_SHUT = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0] CFM_RST_MON_EN = 3'h7;
	localparam logic [3:0] CFM_RST_TIME_CODE = 4'hB;
	localparam logic CFM_RST_WARN_PAUSE = 1'b1;
	localparam logic [15:0] CFM_RST_MASK = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CFM_CLK_HZ = 100_000_000;
	localparam int CFM_SECOND_S = 1;
	localparam int CFM_SECOND_CYCLES = CFM_CLK_HZ * CFM_SECOND_S;
	localparam int CFM_MINUTE_S = 60;
	localparam logic [15:0] CFM_CHECK_MIN_MIN = 16'h001E;
	localparam logic [15:0] CFM_TIMEOUT_BASE_MIN = 16'h003C;
	localparam logic [15:0] CFM_TIMEOUT_STEP_MIN = 16'h001E;
	localparam int CFM_READBACK_UNIT_S = 2048;
	localparam int CFM_READBACK_SHIFT = $clog2(CFM_READBACK_UNIT_S);

	// Charge timeout in seconds for a setting code
	function automatic logic [15:0] cfm_timeout_s(input logic [3:0] code);
		logic [15:0] mins;
		mins = CFM_TIMEOUT_BASE_MIN + 16'(code) * CFM_TIMEOUT_STEP_MIN;
		return 16'(mins * 16'(CFM_MINUTE_S));
	endfunction : cfm_timeout_s

	// Larger of the fixed minimum and a quarter of the timeout
	function automatic logic [15:0] cfm_check_s(input logic [3:0] code);
		logic [15:0] quarter;
		logic [15:0] floor_s;
		quarter = cfm_timeout_s(code) >> 2;
		floor_s = 16'(CFM_CHECK_MIN_MIN * 16'(CFM_MINUTE_S));
		return (quarter > floor_s) ? quarter : floor_s;
	endfunction : cfm_check_s

endpackage : cfm_pkg

// *** src/cfm_event_flags.sv ***
`timescale 1ns/1ps
module cfm_event_flags
	import cfm_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] cond,
	input wire logic clear,
	output logic [WIDTH-1:0] flags
);

	typedef struct packed
	{
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] flags;
	} cfm_flag_state_s;

	cfm_flag_state_s st_q;
	cfm_flag_state_s st_d;

	// ****************************************
	// Edge capture, clear on read
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		st_d.prev = cond;
		if (clear)
		begin
			st_d.flags = '0;
		end
		// New edge beats a coincident clear
		st_d.flags = st_d.flags | (cond & ~st_q.prev);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign flags = st_q.flags;

endmodule : cfm_event_flags

// *** src/cfm_fault_monitor.sv ***
`timescale 1ns/1ps
module cfm_fault_monitor
	import cfm_pkg::*;
#(
	parameter int SECOND_CYCLES = CFM_SECOND_CYCLES,
	parameter bit ROM_CONFIG = 1'b0,
	parameter logic [15:0] KEY_VALUE = 16'h5AA5
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic batt_hot_in,
	input wire logic batt_cold_in,
	input wire logic thermistor_missing,
	input wire logic die_warn_in,
	input wire logic die_shutdown_in,
	input wire logic vbatt_lt_high_in,
	input wire logic vbatt_lt_mid_in,
	input wire logic vbatt_lt_low_in,
	input wire logic charge_active,
	input wire logic trickle_mode,
	input wire logic fast_selected,
	input wire logic timer_reload,
	input wire logic charge_end_evt,
	input wire logic charge_started_evt,
	input wire logic fast_ready_evt,
	input wire logic supply_removed,
	input wire logic power_cycle,
	input wire logic usb_suspend,
	output logic charger_irq_summary,
	output logic charge_suspend,
	output logic charge_stop,
	output logic charge_terminate,
	output logic device_shutdown,
	output logic force_trickle,
	output logic charger_restart,
	output logic charge_timeout
);

	localparam int PRE_W = $clog2(SECOND_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SECOND_CYCLES - 1);

	typedef enum logic [1:0]
	{
		CFM_DB_IDLE,
		CFM_DB_WAIT,
		CFM_DB_PASSED,
		CFM_DB_FAILED
	} cfm_defect_e;

	typedef struct packed
	{
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [15:0] mask;
		logic [2:0] mon_en;
		logic [3:0] time_code;
		logic warn_pause_en;
		logic unlocked;
		logic [PRE_W-1:0] prescale;
		logic [15:0] remain_s;
		logic [15:0] elapsed_s;
		cfm_defect_e dstate;
		logic temp_hold;
		logic shut;
		logic restart;
		logic [15:0] rdata;
	} cfm_state_s;

	cfm_state_s st_q;
	cfm_state_s st_d;

	logic hot;
	logic cold;
	logic ntc_missing;
	logic die_warn;
	logic die_shut;
	logic vlt_high;
	logic vlt_mid;
	logic vlt_low;
	logic hot_act;
	logic cold_act;
	logic ntc_act;
	logic warn_pause;
	logic sec_tick;
	logic timed_out;
	logic wr_ctrl_one;
	logic wr_ctrl_two;
	logic rd_status;
	logic rd_die;
	logic [15:0] chg_cond;
	logic [15:0] chg_flags;
	logic [1:0] die_cond;
	logic [1:0] die_flags;

	// ****************************************
	// Synchronised comparator levels
	// ****************************************
	assign hot = st_q.sync2[0];
	assign cold = st_q.sync2[1];
	assign ntc_missing = st_q.sync2[2];
	assign die_warn = st_q.sync2[3];
	assign die_shut = st_q.sync2[4];
	assign vlt_high = st_q.sync2[5];
	assign vlt_mid = st_q.sync2[6];
	assign vlt_low = st_q.sync2[7];

	assign hot_act = hot & st_q.mon_en[CFM_BIT_HOT_MON-1];
	assign cold_act = cold & st_q.mon_en[CFM_BIT_COLD_MON-1];
	assign ntc_act = ntc_missing & st_q.mon_en[CFM_BIT_NTC_MON-1];
	// Fast charge always pauses; trickle only when enabled
	assign warn_pause = die_warn & (~trickle_mode | st_q.warn_pause_en);

	assign sec_tick = (st_q.prescale == PRE_LAST);
	assign timed_out = charge_active & (st_q.remain_s == 16'h0000);

	assign wr_ctrl_one = reg_wr & (reg_addr == CFM_ADDR_CTRL_ONE);
	assign wr_ctrl_two = reg_wr & (reg_addr == CFM_ADDR_CTRL_TWO);
	assign rd_status = reg_rd & (reg_addr == CFM_ADDR_IRQ_STATUS);
	assign rd_die = reg_rd & (reg_addr == CFM_ADDR_DIE_STATUS);

	// ****************************************
	// Event conditions
	// ****************************************
	always_comb
	begin
		chg_cond = 16'h0000;
		chg_cond[CFM_BIT_HOT] = hot_act;
		chg_cond[CFM_BIT_COLD] = cold_act;
		chg_cond[CFM_BIT_DEFECT] = (st_q.dstate == CFM_DB_FAILED);
		chg_cond[CFM_BIT_TIMEOUT] = timed_out;
		chg_cond[CFM_BIT_END] = charge_end_evt;
		chg_cond[CFM_BIT_START] = charge_started_evt;
		chg_cond[CFM_BIT_FAST_RDY] = fast_ready_evt;
		chg_cond[CFM_BIT_LT_HIGH] = vlt_high;
		// A supply-removal pulse makes its own edge
		chg_cond[CFM_BIT_LT_MID] = vlt_mid | supply_removed;
		chg_cond[CFM_BIT_LT_LOW] = vlt_low | supply_removed;
		die_cond = 2'h0;
		die_cond[CFM_BIT_DIE_WARN] = die_warn;
		die_cond[CFM_BIT_DIE_SHUT] = die_shut;
	end

	cfm_event_flags #(.WIDTH(16)) u_chg_flags
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.cond(chg_cond),
		.clear(rd_status),
		.flags(chg_flags)
	);

	cfm_event_flags #(.WIDTH(2)) u_die_flags
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.cond(die_cond),
		.clear(rd_die),
		.flags(die_flags)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		st_d.sync1 = {vbatt_lt_low_in, vbatt_lt_mid_in, vbatt_lt_high_in, die_shutdown_in,
			die_warn_in, thermistor_missing, batt_cold_in, batt_hot_in};
		st_d.sync2 = st_q.sync1;
		st_d.restart = 1'b0;
		st_d.prescale = sec_tick ? '0 : PRE_W'(st_q.prescale + 1'b1);

		if (reg_wr && reg_addr == CFM_ADDR_KEY)
		begin
			st_d.unlocked = (reg_wdata == KEY_VALUE);
		end
		if (reg_wr && reg_addr == CFM_ADDR_IRQ_MASK)
		begin
			st_d.mask = reg_wdata;
		end
		if (wr_ctrl_one && st_q.unlocked && !ROM_CONFIG)
		begin
			st_d.mon_en = reg_wdata[CFM_BIT_NTC_MON:CFM_BIT_COLD_MON];
		end
		if (wr_ctrl_two)
		begin
			st_d.warn_pause_en = reg_wdata[CFM_BIT_WARN_PAUSE];
			if (st_q.unlocked)
			begin
				st_d.time_code = reg_wdata[CFM_BIT_TIME_LSB+3:CFM_BIT_TIME_LSB];
			end
		end

		// Timer halts while suspended so the limit stretches
		if (timer_reload || (wr_ctrl_two && st_q.unlocked))
		begin
			st_d.remain_s = cfm_timeout_s(st_d.time_code);
		end
		else if (charge_active && !charge_suspend && sec_tick && st_q.remain_s != 16'h0000)
		begin
			st_d.remain_s = st_q.remain_s - 16'h0001;
		end

		if (hot_act || cold_act)
		begin
			st_d.temp_hold = 1'b1;
		end
		else if (power_cycle || !charge_active)
		begin
			st_d.temp_hold = 1'b0;
		end
		if (die_shut)
		begin
			st_d.shut = 1'b1;
		end

		case (st_q.dstate)
			CFM_DB_IDLE:
			begin
				st_d.elapsed_s = 16'h0000;
				if (trickle_mode && charge_active)
				begin
					st_d.dstate = CFM_DB_WAIT;
				end
			end
			CFM_DB_WAIT:
			begin
				if (!trickle_mode)
				begin
					st_d.dstate = CFM_DB_IDLE;
				end
				else if (st_q.elapsed_s >= cfm_check_s(st_q.time_code))
				begin
					st_d.dstate = vlt_low ? CFM_DB_FAILED : CFM_DB_PASSED;
				end
				else if (sec_tick && !charge_suspend)
				begin
					st_d.elapsed_s = st_q.elapsed_s + 16'h0001;
				end
			end
			CFM_DB_PASSED:
			begin
				if (!trickle_mode)
				begin
					st_d.dstate = CFM_DB_IDLE;
				end
			end
			CFM_DB_FAILED:
			begin
				if (!vlt_low || power_cycle || usb_suspend)
				begin
					st_d.dstate = CFM_DB_IDLE;
					st_d.restart = 1'b1;
				end
			end
			default:
			begin
				st_d.dstate = CFM_DB_IDLE;
			end
		endcase

		st_d.rdata = 16'h0000;
		if (reg_rd)
		begin
			case (reg_addr)
				CFM_ADDR_IRQ_STATUS: st_d.rdata = chg_flags;
				CFM_ADDR_IRQ_MASK: st_d.rdata = st_q.mask;
				CFM_ADDR_CTRL_ONE: st_d.rdata[CFM_BIT_NTC_MON:CFM_BIT_COLD_MON] = st_q.mon_en;
				CFM_ADDR_CTRL_TWO:
				begin
					st_d.rdata[CFM_BIT_TIME_LSB+3:CFM_BIT_TIME_LSB] =
						4'(st_q.remain_s >> CFM_READBACK_SHIFT);
					st_d.rdata[CFM_BIT_WARN_PAUSE] = st_q.warn_pause_en;
				end
				CFM_ADDR_DIE_STATUS: st_d.rdata[1:0] = die_flags;
				CFM_ADDR_KEY: st_d.rdata[0] = st_q.unlocked;
				default: st_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.mask <= CFM_RST_MASK;
			st_q.mon_en <= CFM_RST_MON_EN;
			st_q.time_code <= CFM_RST_TIME_CODE;
			st_q.warn_pause_en <= CFM_RST_WARN_PAUSE;
			st_q.remain_s <= cfm_timeout_s(CFM_RST_TIME_CODE);
			st_q.dstate <= CFM_DB_IDLE;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = st_q.rdata;
	assign charger_irq_summary = |(chg_flags & ~st_q.mask);
	assign charge_suspend = hot_act | cold_act | ntc_act | warn_pause;
	assign charge_stop = (st_q.dstate == CFM_DB_FAILED) | st_q.shut;
	assign charge_terminate = st_q.shut;
	assign device_shutdown = st_q.shut;
	// Host sees undervoltage flags unfiltered; it must mask them itself
	assign force_trickle = (fast_selected & vlt_low) | st_q.temp_hold;
	assign charger_restart = st_q.restart;
	assign charge_timeout = timed_out;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_SUMMARY_OR: assert property ($rose(hot_act) && !st_q.mask[CFM_BIT_HOT] && !reg_wr |=> charger_irq_summary)
		else $error("summary interrupt differs from unmasked flags");
	AST_HOT_EDGE_SETS: assert property ($rose(hot_act) |=> chg_flags[CFM_BIT_HOT])
		else $error("hot edge did not set flag");
	AST_READ_CLEARS: assert property (rd_status && !$rose(chg_cond[CFM_BIT_COLD]) |=> !chg_flags[CFM_BIT_COLD])
		else $error("read did not clear flag");
	AST_SET_WINS: assert property (rd_status && $rose(chg_cond[CFM_BIT_HOT]) |=> chg_flags[CFM_BIT_HOT])
		else $error("coincident event lost");
	AST_HOT_SUSPENDS: assert property (hot && st_q.mon_en[1] |-> charge_suspend)
		else $error("hot battery not suspending");
	AST_LOCKED_HOLDS: assert property (wr_ctrl_one && !st_q.unlocked |=> $stable(st_q.mon_en))
		else $error("locked write changed monitor enables");
	AST_SHUT_STICKS: assert property (die_shut |=> charge_terminate && device_shutdown ##1 charge_terminate)
		else $error("shutdown did not terminate charging");
	AST_FAIL_STOPS: assert property (st_q.dstate == CFM_DB_FAILED |-> charge_stop ##1 (charge_stop || charger_restart))
		else $error("defective battery not stopping charge");
	AST_FAST_LOW: assert property (fast_selected && vlt_low |-> force_trickle)
		else $error("fast charge not reverted");
	AST_CLEAR_RESTART: assert property (st_q.dstate == CFM_DB_FAILED && usb_suspend |=> charger_restart && st_q.dstate == CFM_DB_IDLE)
		else $error("defect not cleared by suspend");
	AST_MASK_BLOCKS: assert property (st_q.mask == 16'hFFFF |-> !charger_irq_summary)
		else $error("masked flags raised interrupt");

	COV_DEFECT: cover property (st_q.dstate == CFM_DB_WAIT ##1 st_q.dstate == CFM_DB_FAILED);
	COV_IRQ_READ: cover property (charger_irq_summary ##1 rd_status ##1 !charger_irq_summary);
	COV_UNLOCK_WRITE: cover property (st_q.unlocked && wr_ctrl_one);
	COV_TIMEOUT: cover property ($rose(timed_out));

endmodule : cfm_fault_monitor

// *** test/cfm_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host side of the register port
// ****************************************
module cfm_host_model
	import cfm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [15:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : bus_write

	// Data stands only in the cycle after the strobe
	task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask : bus_read

	// Low and mid undervoltage flags untrustworthy while a feedback flag is up
	function automatic logic [15:0] usable_flags(input logic [15:0] st, input logic feedback);
		return feedback ? (st & ~16'h0003) : st;
	endfunction : usable_flags
endmodule : cfm_host_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import cfm_pkg::*;
;
	localparam int SEC = 4;
	localparam logic [15:0] TB_KEY = 16'h3C3C; // Arbitrary unlock value
	localparam int POS [8] = '{CFM_BIT_HOT, CFM_BIT_COLD, CFM_BIT_END, CFM_BIT_START, CFM_BIT_FAST_RDY,
		CFM_BIT_LT_HIGH, CFM_BIT_LT_MID, CFM_BIT_LT_LOW};
	logic sys_clk;
	logic rst;
	wire [7:0] reg_addr;
	wire [15:0] reg_wdata;
	wire [15:0] reg_rdata;
	wire reg_wr;
	wire reg_rd;
	logic [7:0] evt_v;
	logic missing, warn, shut, active, trickle, fast_sel, reload, supply_rm, pcycle, usb_susp;
	wire summary, suspend, stop, term, shutdown, ftrickle, restart, ctimeout;
	int miscompares;
	int check_count;
	int cycles;
	int n;
	logic [15:0] rd;
	logic [15:0] msk;

	cfm_host_model i_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

	cfm_fault_monitor #(.SECOND_CYCLES(SEC), .ROM_CONFIG(1'b0), .KEY_VALUE(TB_KEY)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .batt_hot_in(evt_v[0]), .batt_cold_in(evt_v[1]),
		.thermistor_missing(missing), .die_warn_in(warn), .die_shutdown_in(shut),
		.vbatt_lt_high_in(evt_v[5]), .vbatt_lt_mid_in(evt_v[6]), .vbatt_lt_low_in(evt_v[7]),
		.charge_active(active), .trickle_mode(trickle), .fast_selected(fast_sel), .timer_reload(reload),
		.charge_end_evt(evt_v[2]), .charge_started_evt(evt_v[3]), .fast_ready_evt(evt_v[4]),
		.supply_removed(supply_rm), .power_cycle(pcycle), .usb_suspend(usb_susp),
		.charger_irq_summary(summary), .charge_suspend(suspend), .charge_stop(stop),
		.charge_terminate(term), .device_shutdown(shutdown), .force_trickle(ftrickle),
		.charger_restart(restart), .charge_timeout(ctimeout));

	// ****************************************
	// Clock, timeout, helpers
	// ****************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : cyc

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// Whole run is about 30k cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{evt_v, missing, warn, shut, active, trickle, fast_sel, reload, supply_rm, pcycle, usb_susp} = '0;
		rst = 1'b1;
		miscompares = 0;
		check_count = 0;
		cycles = 0;
		void'($urandom(32'h5e5ee8f1));
		cyc(10);
		rst <= 1'b0;
		cyc(1);
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		check(rd, 16'h0000);
		i_host.bus_read(CFM_ADDR_IRQ_MASK, rd);
		check(rd, 16'h0000);
		i_host.bus_read(CFM_ADDR_CTRL_ONE, rd);
		check(rd & 16'h000E, 16'h000E);
		i_host.bus_read(CFM_ADDR_CTRL_TWO, rd);
		check(rd & 16'h0F00, 16'h0B00);
		i_host.bus_read(8'h55, rd);
		check(rd, 16'h0000);
		// Eight input-driven edge flags under a mask, random after the two corner masks
		for (int i = 0; i < 8; i++)
		begin
			// Corner masks first: all blocked, then all open
			msk = (i == 0) ? 16'hFFFF : ((i == 1) ? 16'h0000 : 16'($urandom));
			i_host.bus_write(CFM_ADDR_IRQ_MASK, msk);
			evt_v[i] <= 1'b1;
			cyc(5);
			check(16'(summary), 16'(!msk[POS[i]]));
			if (i < 2)
				check(16'(suspend), 16'h0001);
			i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
			check(rd, 16'h0001 << POS[i]);
			evt_v[i] <= 1'b0;
			i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
			check(rd, 16'h0000);
			check(16'(summary), 16'h0000);
		end
		i_host.bus_write(CFM_ADDR_IRQ_MASK, 16'h0000);
		// ****************************************
		// Locked and unlocked monitor enables
		// ****************************************
		i_host.bus_write(CFM_ADDR_CTRL_ONE, 16'h0000);
		i_host.bus_read(CFM_ADDR_CTRL_ONE, rd);
		check(rd & 16'h000E, 16'h000E);
		i_host.bus_write(CFM_ADDR_KEY, TB_KEY);
		i_host.bus_write(CFM_ADDR_CTRL_ONE, 16'h0000);
		i_host.bus_read(CFM_ADDR_CTRL_ONE, rd);
		check(rd & 16'h000E, 16'h0000);
		evt_v[1:0] <= 2'b11;
		missing <= 1'b1;
		cyc(5);
		check(16'(suspend), 16'h0000);
		for (int j = 1; j < 4; j++)
		begin
			i_host.bus_write(CFM_ADDR_CTRL_ONE, 16'h0001 << j);
			cyc(2);
			check(16'(suspend), 16'h0001);
		end
		i_host.bus_write(CFM_ADDR_CTRL_ONE, 16'h000E);
		i_host.bus_write(CFM_ADDR_CTRL_TWO, 16'h0001);
		i_host.bus_write(CFM_ADDR_KEY, 16'h0000);
		evt_v[1:0] <= 2'b00;
		missing <= 1'b0;
		// Shortest code gives a check after 1800 s
		reload <= 1'b1;
		cyc(1);
		reload <= 1'b0;
		i_host.bus_read(CFM_ADDR_CTRL_TWO, rd);
		check(rd & 16'h0F00, 16'h0100);
		// ****************************************
		// Temperature hold and die warning
		// ****************************************
		active <= 1'b1;
		evt_v[0] <= 1'b1;
		cyc(5);
		evt_v[0] <= 1'b0;
		cyc(5);
		check(16'({suspend, ftrickle}), 16'h0001);
		active <= 1'b0;
		warn <= 1'b1;
		cyc(5);
		check(16'(suspend), 16'h0001);
		i_host.bus_read(CFM_ADDR_DIE_STATUS, rd);
		check(rd & 16'h0001, 16'h0001);
		warn <= 1'b0;
		cyc(5);
		check(16'(suspend), 16'h0000);
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		// ****************************************
		// Defective battery, three ways out
		// ****************************************
		for (int m = 0; m < 3; m++)
		begin
			reload <= 1'b1;
			active <= 1'b1;
			trickle <= 1'b1;
			evt_v[7] <= 1'b1;
			cyc(1);
			reload <= 1'b0;
			cyc(1800 * SEC - 20);
			check(16'(stop), 16'h0000);
			for (n = 0; n < 60 && stop !== 1'b1; n++)
				cyc(1);
			check(16'(stop), 16'h0001);
			i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
			check(rd & 16'h2000, 16'h2000);
			if (m == 0)
				evt_v[7] <= 1'b0;
			else if (m == 1)
				pcycle <= 1'b1;
			else
				usb_susp <= 1'b1;
			cyc(1);
			pcycle <= 1'b0;
			for (n = 0; n < 10 && restart !== 1'b1; n++)
				cyc(1);
			check(16'(restart), 16'h0001);
			{usb_susp, active, trickle, evt_v[7]} <= 4'h0;
			cyc(5);
			check(16'(stop), 16'h0000);
		end
		// ****************************************
		// Fast charge on a low battery, supply loss
		// ****************************************
		fast_sel <= 1'b1;
		evt_v[7] <= 1'b1;
		cyc(5);
		check(16'(ftrickle), 16'h0001);
		{fast_sel, evt_v[7]} <= 2'b00;
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		supply_rm <= 1'b1;
		cyc(1);
		supply_rm <= 1'b0;
		cyc(4);
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		check(i_host.usable_flags(rd, 1'b0) & 16'h0003, 16'h0003);
		check(i_host.usable_flags(rd, 1'b1) & 16'h0003, 16'h0000);
		// Hot edge lands on the clearing read strobe
		evt_v[0] <= 1'b1;
		cyc(1);
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		check(rd, 16'h0000);
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		check(rd, 16'h8000);
		evt_v[0] <= 1'b0;
		// ****************************************
		// Charge timer runs out
		// ****************************************
		// Remainder left from the last defect run, well under 1900 s
		active <= 1'b1;
		for (n = 0; n < 1900 * SEC && ctimeout !== 1'b1; n++)
			cyc(1);
		check(16'(ctimeout), 16'h0001);
		i_host.bus_read(CFM_ADDR_IRQ_STATUS, rd);
		check(rd & 16'h1000, 16'h1000);
		i_host.bus_read(CFM_ADDR_CTRL_TWO, rd);
		check(rd & 16'h0F00, 16'h0000);
		active <= 1'b0;
		// ****************************************
		// Die shutdown, latched until reset
		// ****************************************
		shut <= 1'b1;
		cyc(5);
		check(16'({stop, term, shutdown}), 16'h0007);
		i_host.bus_read(CFM_ADDR_DIE_STATUS, rd);
		check(rd & 16'h0002, 16'h0002);
		shut <= 1'b0;
		cyc(5);
		check(16'(shutdown), 16'h0001);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(2);
		check(16'(shutdown), 16'h0000);
		give_verdict();
	end
endmodule : tb_top
